// ### core/lse_top.sv
// Overview of operation
// - Each extended prescaler divides the divide-by-16 output by its factor 1..255.
// - An extended generator runs only while its division register is nonzero.
// - After reset both extended division registers are zero, generators inactive.
// - LIN slave mode stops the conventional and extended generators.
// - LIN master: send_break produces thirteen low bits on the line.
// - LIN master takes its baud from conventional and extended prescalers.
// - LIN slave: send_break has no effect on the transmitter.
// - LIN slave: one LIN generator clocks both transmitter and receiver.
// - header_detect_method picks flagging after break or after identifier.
// - Break detection: break sets receive_data_full and loads 0x00 into data.
// - Break detection: break sets header_detected_flag in control register three.
// - Header interrupt needs header_irq_enable and both CPU mask bits clear.
// - Auto resync on: synch field measured, not loaded, receive_data_full untouched.
// - Auto resync off, break detection: synch field received as normal character, flag set.
// - LIN slave: framing_error reports all framing errors except breaks.
// - Identifier detection: flags set only after identifier, which sits in data.
// - During synch measurement receiver halts and nothing reaches the data register.
// - LIN slave with parity control checks identifier bits seven and eight.
// - LIN divider is 8.4 fixed point; rate is clock over sixteen times it.
`timescale 1ns/10ps
`include "lse_consts.svh"

module lse_ext_div (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic base_tick,
	input wire logic [7:0] factor,
	output logic rate_tick
);
	logic [7:0] cnt_reg;
	wire active = (factor != `LSE_RST_BYTE);
	wire at_end = (cnt_reg == factor - 8'h01);

	// Counter rests at zero when disabled or bypassed
	always_ff @(posedge ref_clk) begin
		if (rst || !enable || !active)
			cnt_reg <= `LSE_RST_BYTE;
		else if (base_tick)
			cnt_reg <= at_end ? `LSE_RST_BYTE : cnt_reg + 8'h01;
	end

	// Zero factor passes the divide-by-16 stage straight through
	assign rate_tick = enable && base_tick && (!active || at_end);

	a_ext_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!enable |=> cnt_reg == `LSE_RST_BYTE) else $error("ext divider ran while disabled");
	a_ext_wrap: assert property (@(posedge ref_clk) disable iff (rst)
		(enable && active && base_tick && at_end && $stable(factor)) ##1 $stable(factor)
		|-> cnt_reg == `LSE_RST_BYTE) else $error("ext divider did not wrap");
endmodule // lse_ext_div

module lse_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] cpu_irq_mask,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic header_irq
);
	// Bus handshake: one wait cycle, then the answer
	logic wait_reg;
	logic [31:0] rdata_reg;
	wire bus_req = avs_read || avs_write;
	wire wr_go = avs_write && !wait_reg && avs_byteenable[0];
	wire rd_go = avs_read && !wait_reg;
	wire wr_status = wr_go && (avs_address == `LSE_OFF_STATUS);
	wire wr_data = wr_go && (avs_address == `LSE_OFF_DATA);
	wire wr_ctrl1 = wr_go && (avs_address == `LSE_OFF_CTRL1);
	wire wr_ctrl2 = wr_go && (avs_address == `LSE_OFF_CTRL2);
	wire wr_ctrl3 = wr_go && (avs_address == `LSE_OFF_CTRL3);
	wire wr_conv = wr_go && (avs_address == `LSE_OFF_CONV_BAUD);
	wire wr_ext_rx = wr_go && (avs_address == `LSE_OFF_EXT_RX);
	wire wr_ext_tx = wr_go && (avs_address == `LSE_OFF_EXT_TX);
	wire wr_mant = wr_go && (avs_address == `LSE_OFF_LIN_MANT);
	wire wr_frac = wr_go && (avs_address == `LSE_OFF_LIN_FRAC);
	wire rd_data = rd_go && (avs_address == `LSE_OFF_DATA);
	wire [7:0] wbyte = avs_writedata[7:0];

	// Software-written configuration
	logic word_len_reg;
	logic parity_en_reg;
	logic tx_en_reg;
	logic rx_en_reg;
	logic send_break_reg;
	lse_pkg::lse_lin_cfg_t lin_cfg_reg;
	logic [7:0] conv_div_reg;
	logic [7:0] ext_rx_prescaler_reg;
	logic [7:0] ext_tx_prescaler_reg;
	logic [7:0] lin_div_mantissa_reg;
	logic [3:0] lin_div_fraction_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			word_len_reg <= 1'b0;
			parity_en_reg <= 1'b0;
			tx_en_reg <= 1'b0;
			rx_en_reg <= 1'b0;
			send_break_reg <= 1'b0;
			lin_cfg_reg <= '0;
			conv_div_reg <= `LSE_RST_BYTE;
			ext_rx_prescaler_reg <= `LSE_RST_BYTE;
			ext_tx_prescaler_reg <= `LSE_RST_BYTE;
			lin_div_mantissa_reg <= `LSE_RST_BYTE;
			lin_div_fraction_reg <= `LSE_RST_FRAC;
		end else begin
			if (wr_ctrl1) begin
				word_len_reg <= wbyte[`LSE_C1_WORD_LEN];
				parity_en_reg <= wbyte[`LSE_C1_PCE];
			end
			if (wr_ctrl2) begin
				tx_en_reg <= wbyte[`LSE_C2_TE];
				rx_en_reg <= wbyte[`LSE_C2_RE];
				send_break_reg <= wbyte[`LSE_C2_SBK];
			end
			if (wr_ctrl3)
				lin_cfg_reg <= lse_pkg::lse_lin_cfg_t'(wbyte[`LSE_C3_CFG_HI:`LSE_C3_CFG_LO]);
			if (wr_conv)
				conv_div_reg <= wbyte;
			if (wr_ext_rx)
				ext_rx_prescaler_reg <= wbyte;
			if (wr_ext_tx)
				ext_tx_prescaler_reg <= wbyte;
			if (wr_mant)
				lin_div_mantissa_reg <= wbyte;
			if (wr_frac)
				lin_div_fraction_reg <= wbyte[3:0];
		end
	end

	wire lin_slave = lin_cfg_reg.lin_enable && lin_cfg_reg.slave_select;

	// Conventional prescaler and divide-by-16 stage, frozen in LIN slave mode
	logic [7:0] conv_cnt_reg;
	logic [3:0] div16_reg;
	wire pre_tick = !lin_slave && (conv_cnt_reg == conv_div_reg);
	wire base_tick = pre_tick && (div16_reg == `LSE_OS_LAST);
	always_ff @(posedge ref_clk) begin
		if (rst || lin_slave) begin
			conv_cnt_reg <= `LSE_RST_BYTE;
			div16_reg <= 4'h0;
		end else begin
			conv_cnt_reg <= pre_tick ? `LSE_RST_BYTE : conv_cnt_reg + 8'h01;
			if (pre_tick)
				div16_reg <= div16_reg + 4'h1;
		end
	end

	wire rx_ext_tick;
	wire tx_ext_tick;
	lse_ext_div u_rx_ext (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(!lin_slave),
		.base_tick(base_tick),
		.factor(ext_rx_prescaler_reg),
		.rate_tick(rx_ext_tick)
	);
	lse_ext_div u_tx_ext (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(!lin_slave),
		.base_tick(base_tick),
		.factor(ext_tx_prescaler_reg),
		.rate_tick(tx_ext_tick)
	);

	// LIN slave generator: fractional accumulator in sixteenths, ticks at clock over divider
	logic [11:0] lin_acc_reg;
	wire [11:0] lin_divider = {lin_div_mantissa_reg, lin_div_fraction_reg};
	wire [12:0] lin_sum = {1'b0, lin_acc_reg} + `LSE_LIN_DIVIDER_STEP;
	wire lin_run = lin_slave && (lin_div_mantissa_reg != `LSE_RST_BYTE);
	wire lin_tick = lin_run && (lin_sum >= {1'b0, lin_divider});
	always_ff @(posedge ref_clk) begin
		if (rst || !lin_run)
			lin_acc_reg <= 12'h000;
		else
			lin_acc_reg <= lin_tick ? 12'(lin_sum - {1'b0, lin_divider}) : lin_sum[11:0];
	end

	// One shared LIN tick replaces both prescaler outputs in slave mode
	wire rx_rate_tick = lin_slave ? lin_tick : rx_ext_tick;
	wire tx_rate_tick = lin_slave ? lin_tick : tx_ext_tick;

	// Transmitter
	lse_pkg::lse_tx_state_t tx_state_reg;
	logic [3:0] tx_os_reg;
	logic [3:0] tx_bit_reg;
	logic [3:0] tx_brk_len_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] tx_buf_reg;
	logic tx_empty_reg;
	logic brk_pend_reg;
	logic sbk_prev_reg;
	logic tx_pin_reg;
	wire tx_bit_end = tx_rate_tick && (tx_os_reg == `LSE_OS_LAST);
	wire tx_idle = (tx_state_reg == lse_pkg::TX_IDLE);
	wire brk_allow = !lin_slave;
	wire sbk_rise = send_break_reg && !sbk_prev_reg;
	wire brk_start = tx_idle && tx_en_reg && brk_pend_reg;
	wire tx_load = tx_idle && tx_en_reg && !brk_pend_reg && !tx_empty_reg;

	// Break is queued so that it follows the word in flight
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			brk_pend_reg <= 1'b0;
			sbk_prev_reg <= 1'b0;
			tx_empty_reg <= 1'b1;
			tx_buf_reg <= `LSE_RST_BYTE;
		end else begin
			sbk_prev_reg <= send_break_reg;
			if (sbk_rise && brk_allow)
				brk_pend_reg <= 1'b1;
			else if (brk_start)
				brk_pend_reg <= 1'b0;
			if (wr_data)
				tx_buf_reg <= wbyte;
			tx_empty_reg <= tx_load ? 1'b1 : (wr_data ? 1'b0 : tx_empty_reg);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_state_reg <= lse_pkg::TX_IDLE;
			tx_os_reg <= 4'h0;
			tx_bit_reg <= 4'h0;
			tx_brk_len_reg <= `LSE_STD_BRK_BITS;
			tx_shift_reg <= `LSE_RST_BYTE;
			tx_pin_reg <= 1'b1;
		end else begin
			tx_os_reg <= tx_idle ? 4'h0 : (tx_rate_tick ? tx_os_reg + 4'h1 : tx_os_reg);
			case (tx_state_reg)
				lse_pkg::TX_IDLE: begin
					tx_pin_reg <= 1'b1;
					tx_bit_reg <= 4'h0;
					if (brk_start) begin
						tx_state_reg <= lse_pkg::TX_BREAK;
						tx_brk_len_reg <= lin_cfg_reg.lin_enable ? `LSE_LIN_BRK_BITS
							: `LSE_STD_BRK_BITS;
						tx_pin_reg <= 1'b0;
					end else if (tx_load) begin
						tx_state_reg <= lse_pkg::TX_START;
						tx_shift_reg <= tx_buf_reg;
						tx_pin_reg <= 1'b0;
					end
				end
				lse_pkg::TX_START: begin
					if (tx_bit_end) begin
						tx_state_reg <= lse_pkg::TX_DATA;
						tx_pin_reg <= tx_shift_reg[0];
					end
				end
				lse_pkg::TX_DATA: begin
					if (tx_bit_end) begin
						if (tx_bit_reg == `LSE_DATA_LAST) begin
							tx_state_reg <= lse_pkg::TX_STOP;
							tx_pin_reg <= 1'b1;
						end else begin
							tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
							tx_pin_reg <= tx_shift_reg[1];
							tx_bit_reg <= tx_bit_reg + 4'h1;
						end
					end
				end
				lse_pkg::TX_BREAK: begin
					if (tx_bit_end) begin
						if (tx_bit_reg == tx_brk_len_reg - 4'h1) begin
							tx_state_reg <= lse_pkg::TX_STOP;
							tx_pin_reg <= 1'b1;
						end else
							tx_bit_reg <= tx_bit_reg + 4'h1;
					end
				end
				lse_pkg::TX_STOP: begin
					if (tx_bit_end)
						tx_state_reg <= lse_pkg::TX_IDLE;
				end
				default: tx_state_reg <= lse_pkg::TX_IDLE;
			endcase
		end
	end

	// Receive line synchroniser; the second stage feeds logic, the third only the falling-edge detect
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic rx_prev_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rx_pin;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	// Receiver
	lse_pkg::lse_rx_state_t rx_state_reg;
	logic [3:0] rx_os_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic rx_wait_high_reg;
	logic [1:0] hdr_pos_reg;
	logic [2:0] edge_cnt_reg;
	wire rx_bit_end = rx_rate_tick && (rx_os_reg == `LSE_OS_LAST);
	wire rx_done = (rx_state_reg == lse_pkg::RX_STOP) && rx_bit_end;
	wire char_break = (rx_shift_reg == `LSE_RST_BYTE) && !rx_sync_reg;
	wire in_hdr_brk = rx_done && lin_slave && char_break;
	wire in_synch = rx_done && lin_slave && !char_break && (hdr_pos_reg == `LSE_HDR_SYNCH);
	wire in_ident = rx_done && lin_slave && !char_break && (hdr_pos_reg == `LSE_HDR_IDENT);
	wire in_plain = rx_done && !in_hdr_brk && !in_synch && !in_ident;
	wire hdm = lin_cfg_reg.header_detect_method;
	wire fall_edge = rx_prev_reg && !rx_sync_reg;
	wire measure_end = (rx_state_reg == lse_pkg::RX_MEASURE) && fall_edge
		&& (edge_cnt_reg == `LSE_SYNCH_LAST_EDGE);

	// Data register load and flag sets per header position
	wire rdr_load = ((in_hdr_brk || in_synch) && !hdm) || in_ident || in_plain;
	wire hdf_set = (in_hdr_brk && !hdm) || (in_ident && hdm);
	wire fe_set = rx_done && !rx_sync_reg && !(lin_slave && char_break);
	wire id_p0 = rx_shift_reg[0] ^ rx_shift_reg[1] ^ rx_shift_reg[2] ^ rx_shift_reg[4];
	wire id_p1 = !(rx_shift_reg[1] ^ rx_shift_reg[3] ^ rx_shift_reg[4] ^ rx_shift_reg[5]);
	wire id_bad = (rx_shift_reg[6] != id_p0) || (rx_shift_reg[7] != id_p1);
	wire pe_set = in_ident && parity_en_reg && id_bad;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_state_reg <= lse_pkg::RX_IDLE;
			rx_os_reg <= 4'h0;
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= `LSE_RST_BYTE;
			rx_wait_high_reg <= 1'b0;
			edge_cnt_reg <= 3'h0;
		end else begin
			case (rx_state_reg)
				lse_pkg::RX_IDLE: begin
					rx_os_reg <= 4'h0;
					rx_bit_reg <= 4'h0;
					if (rx_sync_reg)
						rx_wait_high_reg <= 1'b0;
					else if (rx_en_reg && !rx_wait_high_reg)
						rx_state_reg <= lse_pkg::RX_START;
				end
				lse_pkg::RX_START: begin
					if (rx_rate_tick)
						rx_os_reg <= rx_os_reg + 4'h1;
					if (rx_rate_tick && rx_os_reg == `LSE_OS_MID) begin
						rx_os_reg <= 4'h0;
						rx_state_reg <= rx_sync_reg ? lse_pkg::RX_IDLE : lse_pkg::RX_DATA;
					end
				end
				lse_pkg::RX_DATA: begin
					if (rx_rate_tick)
						rx_os_reg <= rx_os_reg + 4'h1;
					if (rx_bit_end) begin
						rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
						rx_bit_reg <= rx_bit_reg + 4'h1;
						if (rx_bit_reg == `LSE_DATA_LAST)
							rx_state_reg <= lse_pkg::RX_STOP;
					end
				end
				lse_pkg::RX_STOP: begin
					if (rx_rate_tick)
						rx_os_reg <= rx_os_reg + 4'h1;
					if (rx_bit_end) begin
						rx_wait_high_reg <= !rx_sync_reg;
						edge_cnt_reg <= 3'h0;
						rx_state_reg <= (in_hdr_brk && lin_cfg_reg.auto_resync_enable)
							? lse_pkg::RX_MEASURE : lse_pkg::RX_IDLE;
					end
				end
				lse_pkg::RX_MEASURE: begin
					// Character machine idles here; the synch field never reaches the shifter
					if (fall_edge)
						edge_cnt_reg <= edge_cnt_reg + 3'h1;
					if (measure_end || !lin_slave || !rx_en_reg) begin
						rx_wait_high_reg <= 1'b1; // Last edge leaves the line low
						rx_state_reg <= lse_pkg::RX_IDLE;
					end
				end
				default: rx_state_reg <= lse_pkg::RX_IDLE;
			endcase
		end
	end

	// Header position: break counts as the first character
	always_ff @(posedge ref_clk) begin
		if (rst || !lin_slave)
			hdr_pos_reg <= `LSE_HDR_NONE;
		else if (in_hdr_brk)
			hdr_pos_reg <= `LSE_HDR_SYNCH;
		else if (in_synch || measure_end)
			hdr_pos_reg <= `LSE_HDR_IDENT;
		else if (in_ident)
			hdr_pos_reg <= `LSE_HDR_NONE;
	end

	// Receive data and sticky flags; a set in the clearing cycle wins
	logic [7:0] data_reg;
	logic receive_data_full_reg;
	logic framing_error_reg;
	logic parity_error_reg;
	logic header_detected_flag_reg;
	logic header_irq_reg;
	wire clr_fe = wr_status && wbyte[`LSE_ST_FE];
	wire clr_pe = wr_status && wbyte[`LSE_ST_PE];
	wire clr_hdf = wr_ctrl3 && wbyte[`LSE_C3_HDF];
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			data_reg <= `LSE_RST_BYTE;
			receive_data_full_reg <= 1'b0;
			framing_error_reg <= 1'b0;
			parity_error_reg <= 1'b0;
			header_detected_flag_reg <= 1'b0;
			header_irq_reg <= 1'b0;
		end else begin
			if (rdr_load)
				data_reg <= rx_shift_reg;
			receive_data_full_reg <= rdr_load || (receive_data_full_reg && !rd_data);
			framing_error_reg <= fe_set || (framing_error_reg && !clr_fe);
			parity_error_reg <= pe_set || (parity_error_reg && !clr_pe);
			header_detected_flag_reg <= hdf_set || (header_detected_flag_reg && !clr_hdf);
			header_irq_reg <= header_detected_flag_reg && lin_cfg_reg.header_irq_enable
				&& (cpu_irq_mask == 2'b00);
		end
	end

	// Read mux; unmapped offsets read zero
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = `LSE_RST_BYTE;
		case (avs_address)
			`LSE_OFF_STATUS: rd_byte = {tx_empty_reg, 1'b0, receive_data_full_reg, 3'b000,
				framing_error_reg, parity_error_reg};
			`LSE_OFF_DATA: rd_byte = data_reg;
			`LSE_OFF_CTRL1: rd_byte = {3'b000, word_len_reg, 1'b0, parity_en_reg, 2'b00};
			`LSE_OFF_CTRL2: rd_byte = {4'h0, tx_en_reg, rx_en_reg, 1'b0, send_break_reg};
			`LSE_OFF_CTRL3: rd_byte = {lin_cfg_reg, 2'b00, header_detected_flag_reg};
			`LSE_OFF_CONV_BAUD: rd_byte = conv_div_reg;
			`LSE_OFF_EXT_RX: rd_byte = ext_rx_prescaler_reg;
			`LSE_OFF_EXT_TX: rd_byte = ext_tx_prescaler_reg;
			`LSE_OFF_LIN_MANT: rd_byte = lin_div_mantissa_reg;
			`LSE_OFF_LIN_FRAC: rd_byte = {4'h0, lin_div_fraction_reg};
			default: rd_byte = `LSE_RST_BYTE;
		endcase
	end

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else begin
			wait_reg <= !(bus_req && wait_reg);
			if (bus_req && wait_reg)
				rdata_reg <= {24'h000000, rd_byte};
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign tx_pin = tx_pin_reg;
	assign header_irq = header_irq_reg;

	a_ext_reset: assert property (@(posedge ref_clk)
		$fell(rst) |-> ext_rx_prescaler_reg == `LSE_RST_BYTE && ext_tx_prescaler_reg == `LSE_RST_BYTE)
		else $error("extended prescalers not cleared by reset");
	a_slave_conv_off: assert property (@(posedge ref_clk) disable iff (rst)
		lin_slave |-> !base_tick && !rx_ext_tick && !tx_ext_tick)
		else $error("standard generators ran in slave mode");
	a_bypass_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(!lin_slave && ext_rx_prescaler_reg == `LSE_RST_BYTE) |-> rx_rate_tick == base_tick)
		else $error("zero prescaler not bypassed");
	a_break_thirteen: assert property (@(posedge ref_clk) disable iff (rst)
		(brk_start && lin_cfg_reg.lin_enable) |=> tx_state_reg == lse_pkg::TX_BREAK
		&& tx_brk_len_reg == `LSE_LIN_BRK_BITS && !tx_pin_reg) else $error("LIN break not 13 bits");
	a_slave_no_break: assert property (@(posedge ref_clk) disable iff (rst)
		(lin_slave && !brk_pend_reg) ##1 lin_slave |-> !brk_pend_reg)
		else $error("slave queued a break");
	a_shared_tick: assert property (@(posedge ref_clk) disable iff (rst)
		lin_slave |-> rx_rate_tick == tx_rate_tick) else $error("slave rx and tx rates differ");
	a_break_header: assert property (@(posedge ref_clk) disable iff (rst)
		(in_hdr_brk && !hdm) |=> header_detected_flag_reg && receive_data_full_reg
		&& data_reg == `LSE_RST_BYTE) else $error("break header not flagged");
	a_ident_only: assert property (@(posedge ref_clk) disable iff (rst)
		(lin_slave && hdm && rx_done && !in_ident) |-> !hdf_set)
		else $error("header flagged before identifier");
	a_measure_halt: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_state_reg == lse_pkg::RX_MEASURE) |=> $stable(data_reg) && !rdr_load)
		else $error("data moved during synch measurement");
	a_fe_no_break: assert property (@(posedge ref_clk) disable iff (rst)
		(in_hdr_brk && !framing_error_reg) |=> !framing_error_reg)
		else $error("break raised framing error");
	a_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
		(header_irq_reg && $past(cpu_irq_mask) != 2'b00) |-> 1'b0)
		else $error("header interrupt while masked");

	c_break_sent: cover property (@(posedge ref_clk) disable iff (rst)
		tx_state_reg == lse_pkg::TX_BREAK ##1 tx_state_reg == lse_pkg::TX_STOP);
	c_header_irq: cover property (@(posedge ref_clk) disable iff (rst) $rose(header_irq_reg));
	c_parity_bad: cover property (@(posedge ref_clk) disable iff (rst) pe_set);
	c_measure_done: cover property (@(posedge ref_clk) disable iff (rst) measure_end);
endmodule // lse_top

// ### core/lse_consts.svh
`ifndef LSE_CONSTS_SVH
`define LSE_CONSTS_SVH

// Register byte offsets, one aligned word each
`define LSE_OFF_STATUS 6'h00
`define LSE_OFF_DATA 6'h04
`define LSE_OFF_CTRL1 6'h08
`define LSE_OFF_CTRL2 6'h0C
`define LSE_OFF_CTRL3 6'h10
`define LSE_OFF_CONV_BAUD 6'h14
`define LSE_OFF_EXT_RX 6'h18
`define LSE_OFF_EXT_TX 6'h1C
`define LSE_OFF_LIN_MANT 6'h20
`define LSE_OFF_LIN_FRAC 6'h24

// Field positions
`define LSE_ST_PE 0
`define LSE_ST_FE 1
`define LSE_ST_RECEIVE_DATA_FULL 5
`define LSE_ST_TRANSMIT_EMPTY 7
`define LSE_C1_PCE 2
`define LSE_C1_WORD_LEN 4
`define LSE_C2_SBK 0
`define LSE_C2_RE 2
`define LSE_C2_TE 3
`define LSE_C3_HDF 0
`define LSE_C3_CFG_LO 3
`define LSE_C3_CFG_HI 7

// Reset values
`define LSE_RST_BYTE 8'h00
`define LSE_RST_FRAC 4'h0

// Bit timing
`define LSE_OS_LAST 4'hF
`define LSE_OS_MID 4'h7
`define LSE_DATA_LAST 4'h7
`define LSE_LIN_BRK_BITS 4'hD
`define LSE_STD_BRK_BITS 4'hA
`define LSE_SYNCH_LAST_EDGE 3'h4
`define LSE_LIN_DIVIDER_STEP 13'h0010

// Header position after a break
`define LSE_HDR_NONE 2'h0
`define LSE_HDR_SYNCH 2'h1
`define LSE_HDR_IDENT 2'h2

`endif

// ### core/lse_pkg.sv
package lse_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP} lse_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_MEASURE} lse_rx_state_t;
	// LIN configuration held in the third control register
	typedef struct packed {
		logic lin_enable;
		logic slave_select;
		logic header_detect_method;
		logic header_irq_enable;
		logic auto_resync_enable;
	} lse_lin_cfg_t;
endpackage

// ### verif/lse_lin_node.sv
`timescale 1ns/10ps
// Another LIN node on the line; recessive high through the pull-up
module lse_lin_node #(
	parameter int BIT_CLKS = 16
) (
	input wire logic ref_clk,
	output logic rx_line
);
	// Recessive between frames
	initial begin
		rx_line = 1'b1;
	end
	// Whole bit times at the node's rate
	task automatic bits(input int n);
		repeat (n * BIT_CLKS) @(posedge ref_clk);
	endtask
	// Thirteen dominant bits, then a recessive gap
	task automatic send_brk();
		rx_line <= 1'b0;
		bits(13);
		rx_line <= 1'b1;
		bits(2);
	endtask
	// Start, data LSB first, stop, short idle gap
	task automatic send_byte(input logic [7:0] b);
		rx_line <= 1'b0;
		bits(1);
		for (int i = 0; i < 8; i++) begin
			rx_line <= b[i];
			bits(1);
		end
		rx_line <= 1'b1;
		bits(2);
	endtask
endmodule // lse_lin_node

// ### verif/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
	logic ref_clk = 1'b0;
	logic rst;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] cpu_irq_mask;
	logic [7:0] txb;
	logic rx_pin;
	logic tx_pin;
	logic header_irq;
	logic [31:0] q;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	int l0;
	int l2;
	always #25 ref_clk = ~ref_clk;
	lse_top DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cpu_irq_mask(cpu_irq_mask), .rx_pin(rx_pin), .tx_pin(tx_pin), .header_irq(header_irq));
	// LIN divider 1.0 gives sixteen clocks per bit
	lse_lin_node #(.BIT_CLKS(16)) node (.ref_clk(ref_clk), .rx_line(rx_pin));
	// One request held until waitrequest is seen low, then an idle cycle
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, {24'h000000, e})
	endtask
	// Pulse send_break with the transmitter on and time the low stretch
	task automatic brk_len(output int len);
		bus(1'b1, 6'h0C, 8'h09);
		bus(1'b1, 6'h0C, 8'h08);
		len = 0;
		while (tx_pin !== 1'b0) @(posedge ref_clk);
		while (tx_pin === 1'b0) begin
			@(posedge ref_clk);
			len++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Cut a hang short; the tests need about a seventh of this
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			failures++;
			report_and_stop();
		end
	end
	// Main sequence
	initial begin
		rst <= 1'b1;
		avs_address <= 6'h00;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h00000000;
		avs_byteenable <= 4'hF;
		cpu_irq_mask <= 2'h0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdchk(6'h18, 8'h00);
		rdchk(6'h1C, 8'h00);
		rdchk(6'h3C, 8'h00);
		bus(1'b1, 6'h18, 8'hFF);
		rdchk(6'h18, 8'hFF);
		// A write without byte lane 0 must leave the register alone
		avs_byteenable <= 4'hE;
		bus(1'b1, 6'h18, 8'h00);
		avs_byteenable <= 4'hF;
		rdchk(6'h18, 8'hFF);
		$display("test registers done");
		bus(1'b1, 6'h10, 8'h80);
		brk_len(l0);
		bus(1'b1, 6'h1C, 8'h02);
		brk_len(l2);
		// 13 bits of 16 ticks; the first tick lands up to one tick period after the start
		`CHK(l0 > 3312, 1'b1)
		`CHK(l0 <= 3328, 1'b1)
		`CHK(l2 > 6624 && l2 <= 6656, 1'b1)
		$display("test master break done");
		// Slave setup; a conventional divider of 5 must not affect the LIN bit rate
		bus(1'b1, 6'h14, 8'h05);
		bus(1'b1, 6'h10, 8'hD0);
		bus(1'b1, 6'h08, 8'h04);
		bus(1'b1, 6'h20, 8'h01);
		bus(1'b1, 6'h0C, 8'h0D);
		bus(1'b1, 6'h0C, 8'h0C);
		l0 = 0;
		repeat (400) begin
			@(posedge ref_clk);
			if (tx_pin !== 1'b1) l0++;
		end
		`CHK(l0, 0)
		// Slave transmit at the shared LIN rate, each bit sampled near its middle
		bus(1'b1, 6'h04, 8'h55);
		while (tx_pin !== 1'b0) @(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge ref_clk);
			txb[i] = tx_pin;
		end
		`CHK(txb, 8'h55)
		repeat (16) @(posedge ref_clk);
		`CHK(tx_pin, 1'b1)
		node.send_brk();
		rdchk(6'h00, 8'hA0);
		rdchk(6'h10, 8'hD1);
		`CHK(header_irq, 1'b1)
		cpu_irq_mask <= 2'h2;
		repeat (2) @(posedge ref_clk);
		`CHK(header_irq, 1'b0)
		cpu_irq_mask <= 2'h0;
		repeat (2) @(posedge ref_clk);
		`CHK(header_irq, 1'b1)
		cpu_irq_mask <= 2'h1;
		repeat (2) @(posedge ref_clk);
		`CHK(header_irq, 1'b0)
		cpu_irq_mask <= 2'h0;
		rdchk(6'h04, 8'h00);
		node.send_byte(8'h55);
		rdchk(6'h04, 8'h55);
		node.send_byte(8'h80);
		rdchk(6'h04, 8'h80);
		rdchk(6'h00, 8'h80);
		$display("test break detection done");
		// Header detection runs without mute mode, which this receiver lacks
		// Identifier detection; the identifier carries a bad second parity bit
		bus(1'b1, 6'h10, 8'hE1);
		node.send_brk();
		rdchk(6'h10, 8'hE0);
		node.send_byte(8'h55);
		rdchk(6'h00, 8'h80);
		node.send_byte(8'h00);
		rdchk(6'h00, 8'hA1);
		rdchk(6'h10, 8'hE1);
		rdchk(6'h04, 8'h00);
		$display("test identifier detection done");
		// Auto resync: the synch field is swallowed by the measurement
		bus(1'b1, 6'h00, 8'h03);
		bus(1'b1, 6'h10, 8'hC9);
		node.send_brk();
		rdchk(6'h04, 8'h00);
		node.send_byte(8'h55);
		rdchk(6'h00, 8'h80);
		node.send_byte(8'h80);
		rdchk(6'h04, 8'h80);
		$display("test resync done");
		report_and_stop();
	end
endmodule // tb
